// File: src/tpm_map.svh
// Offsets, field positions, reset values and timing counts of the port data mux control.
// Assumes an APB slave with 32-bit data at the byte addresses below.
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TPM_OFS_MUX_CTRL 12'h000
`define TPM_OFS_PULL_CTRL 12'h004
`define TPM_OFS_CMP_EN 12'h008
`define TPM_OFS_IRQ_STAT 12'h00c
`define TPM_OFS_IRQ_CLR 12'h010
`define TPM_OFS_IRQ_EN 12'h014
`define TPM_OFS_PORT_STAT 12'h018

// ----------------------------------------------------------------------
// Mux control fields
// ----------------------------------------------------------------------
`define TPM_MC_ORIENT_LO 0
`define TPM_MC_PAIR_LO 2
`define TPM_MC_SB_LO 5
`define TPM_MC_EP_TX 8
`define TPM_MC_ILIM_HI 9
`define TPM_MC_CABLE_EN 10
`define TPM_MC_RST 32'h0000_0000

// Port pin count: sideband one, sideband two, top d+, top d-, bottom d+, bottom d-
`define TPM_NPINS 6
`define TPM_OVC_IRQ_BIT 6

// Comparator edge-event debounce in core cycles (1 cycle)
`define TPM_CMP_HOLD_NS 40
`define TPM_CLK_NS 40
`define TPM_CMP_HOLD_CYC ((`TPM_CMP_HOLD_NS + `TPM_CLK_NS - 1) / `TPM_CLK_NS)

`endif

// File: src/tpm_pkg.sv
// Types of the port data mux control.
// Assumes tpm_map.svh supplies the numeric constants.
package tpm_pkg;
   typedef enum logic [2:0] {
      TPM_ORIENT_OPEN = 3'b001,
      TPM_ORIENT_UP = 3'b010,
      TPM_ORIENT_FLIP = 3'b100
   } tpm_orient_t;

   // Source on the d+/d- pairs
   typedef enum logic [2:0] {
      TPM_PAIR_NONE = 3'h0,
      TPM_PAIR_ROOT = 3'h1,
      TPM_PAIR_ENDPT = 3'h2,
      TPM_PAIR_DEBUG = 3'h3,
      TPM_PAIR_AUX = 3'h4
   } tpm_pair_src_t;

   // Source on the sideband crossbar
   typedef enum logic [2:0] {
      TPM_SB_NONE = 3'h0,
      TPM_SB_DEBUG = 3'h1,
      TPM_SB_DBG1 = 3'h2,
      TPM_SB_AUX = 3'h3
   } tpm_sb_src_t;
endpackage : tpm_pkg

// File: src/tpm_port_mux.sv
// Port data multiplexer control: orientation-aware path selects, pulls, clamps,
// edge comparators with interrupt, endpoint pull-up and cable-supply control.
// Assumes an APB master on sys_clk; port sense inputs are asynchronous pins.
//
// Function
// [RQ1] Path selection depends on both orientation and the selected interface source.
// [RQ2] Reversed orientation swaps the top and bottom d+/d- pair roles.
// [RQ3] Sideband crossbar swaps its two output pins with orientation.
// [RQ4] Each pair source has fixed top and bottom pins, never crossed.
// [RQ5] Upside-up: clock, aux line, aux plus on pin one; data, aux minus pin two.
// [RQ6] Only d+/d- pairs and sideband pins are switched here.
// [RQ7] Digital paths run no faster than the core clock allows.
// [RQ8] Enabled per-pin edge comparators raise an interrupt on every pin transition.
// [RQ9] Firmware can disconnect comparators on pins carrying analog levels.
// [RQ10] Every port output has its own configurable pull-up and pull-down.
// [RQ11] Clamp attaches only while a second-stage path to the pin is closed.
// [RQ12] Endpoint is low speed only; only control endpoint zero is handled.
// [RQ13] Endpoint zero enumerates advertising the billboard class.
// [RQ14] Endpoint pull-up is disconnected whenever the endpoint transmits.
// [RQ15] In receive, pull-up goes to top or bottom d- by orientation.
// [RQ16] Cable-supply limit has two selectable levels; limiting engages above it.
// [RQ17] One config-channel pin gets cable supply, the other the modem.
// [RQ18] Never two sources on one pin; all paths open while orientation unresolved.
//
// Register access over APB and the register offsets were left to the implementer.
`include "tpm_map.svh"

module tpm_port_mux (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] port_pin_sense,
   input wire logic cable_overcurrent,
   output logic [4:0] top_pair_sel,
   output logic [4:0] bottom_pair_sel,
   output logic [3:0] sideband_pin_one_sel,
   output logic [3:0] sideband_pin_two_sel,
   output logic [5:0] pin_pullup_en,
   output logic [5:0] pin_pulldown_en,
   output logic [5:0] pin_clamp_en,
   output logic [5:0] pin_cmp_connect,
   output logic endpoint_pullup_top,
   output logic endpoint_pullup_bottom,
   output logic endpoint_low_speed_only,
   output logic cable_supply_current_limit,
   output logic cable_supply_to_cc_one,
   output logic cable_supply_to_cc_two,
   output logic modem_to_cc_one,
   output logic modem_to_cc_two,
   output logic irq
);
   import tpm_pkg::*;

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic [31:0] mux_ctrl_r;
   logic [11:0] pull_ctrl_r;
   logic [5:0] cmp_en_r;
   logic [6:0] irq_stat_r;
   logic [6:0] irq_en_r;
   logic [5:0] sense_s1_r;
   logic [5:0] sense_s2_r;
   logic [5:0] sense_d_r;
   logic ovc_s1_r;
   logic ovc_s2_r;
   logic wr_acc;
   logic rd_acc;
   logic addr_ok;
   logic [6:0] irq_set;
   logic [6:0] irq_clr;
   logic [1:0] orient_bits;
   tpm_orient_t orient;
   tpm_pair_src_t pair_src;
   tpm_sb_src_t sb_src;
   logic ep_tx;
   logic [4:0] pair_onehot;
   logic [3:0] sb_onehot;
   logic [3:0] sb_one_nxt;
   logic [3:0] sb_two_nxt;
   logic [5:0] path_closed;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   always_comb begin
      unique case (paddr)
         `TPM_OFS_MUX_CTRL, `TPM_OFS_PULL_CTRL, `TPM_OFS_CMP_EN, `TPM_OFS_IRQ_STAT,
         `TPM_OFS_IRQ_CLR, `TPM_OFS_IRQ_EN, `TPM_OFS_PORT_STAT: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Zero-wait slave: pready is high in every access phase
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mux_ctrl_r <= `TPM_MC_RST;
         pull_ctrl_r <= 12'h000;
         cmp_en_r <= 6'h00;
         irq_en_r <= 7'h00;
      end else if (wr_acc && pready) begin
         unique case (paddr)
            `TPM_OFS_MUX_CTRL: mux_ctrl_r <= {21'h000000, pwdata[10:0]};
            `TPM_OFS_PULL_CTRL: pull_ctrl_r <= pwdata[11:0]; // [RQ10]
            `TPM_OFS_CMP_EN: cmp_en_r <= pwdata[5:0]; // [RQ9]
            `TPM_OFS_IRQ_EN: irq_en_r <= pwdata[6:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            `TPM_OFS_MUX_CTRL: prdata <= mux_ctrl_r;
            `TPM_OFS_PULL_CTRL: prdata <= {20'h00000, pull_ctrl_r};
            `TPM_OFS_CMP_EN: prdata <= {26'h0000000, cmp_en_r};
            `TPM_OFS_IRQ_STAT: prdata <= {25'h0000000, irq_stat_r};
            `TPM_OFS_IRQ_EN: prdata <= {25'h0000000, irq_en_r};
            `TPM_OFS_PORT_STAT: prdata <= {24'h000000, ovc_s2_r, cable_supply_current_limit,
                                           sense_d_r}; // [RQ16]
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Edge comparators
   // ----------------------------------------------------------------------
   // Two-stage sync keeps every event inside the core clock rate
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sense_s1_r <= 6'h00;
         sense_s2_r <= 6'h00;
         sense_d_r <= 6'h00;
         ovc_s1_r <= 1'b0;
         ovc_s2_r <= 1'b0;
      end else begin
         // Overcurrent flag comes from the analog side, so it is synchronised too
         ovc_s1_r <= cable_overcurrent;
         ovc_s2_r <= ovc_s1_r; // [RQ16]
         sense_s1_r <= port_pin_sense;
         sense_s2_r <= sense_s1_r; // [RQ7]
         sense_d_r <= sense_s2_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `TPM_NPINS; gi++) begin : g_cmp
         assign irq_set[gi] = cmp_en_r[gi] && (sense_s2_r[gi] ^ sense_d_r[gi]); // [RQ8]
      end
   endgenerate
   assign irq_set[`TPM_OVC_IRQ_BIT] = cable_supply_current_limit;
   assign irq_clr = (wr_acc && pready && paddr == `TPM_OFS_IRQ_CLR) ? pwdata[6:0] : 7'h00;

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_r <= 7'h00;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set; // [RQ8]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
      end
   end

   // ----------------------------------------------------------------------
   // Path selection
   // ----------------------------------------------------------------------
   assign orient_bits = mux_ctrl_r[`TPM_MC_ORIENT_LO +: 2];
   assign pair_src = tpm_pair_src_t'(mux_ctrl_r[`TPM_MC_PAIR_LO +: 3]);
   assign sb_src = tpm_sb_src_t'(mux_ctrl_r[`TPM_MC_SB_LO +: 3]);
   assign ep_tx = mux_ctrl_r[`TPM_MC_EP_TX];

   // 00 or 11 leave the orientation unresolved
   always_comb begin
      unique case (orient_bits)
         2'b01: orient = TPM_ORIENT_UP;
         2'b10: orient = TPM_ORIENT_FLIP;
         default: orient = TPM_ORIENT_OPEN;
      endcase
   end

   // One-hot select per pin: at most one source can close onto it
   always_comb begin
      unique case (pair_src)
         TPM_PAIR_ROOT: pair_onehot = 5'b00001;
         TPM_PAIR_ENDPT: pair_onehot = 5'b00010;
         TPM_PAIR_DEBUG: pair_onehot = 5'b00100;
         TPM_PAIR_AUX: pair_onehot = 5'b01000;
         default: pair_onehot = 5'b00000; // [RQ18]
      endcase
      // Bit 0 debug clock/data, bit 1 aux line, bit 2 aux pair
      unique case (sb_src)
         TPM_SB_DEBUG: sb_onehot = 4'b0001;
         TPM_SB_DBG1: sb_onehot = 4'b0010;
         TPM_SB_AUX: sb_onehot = 4'b0100;
         default: sb_onehot = 4'b0000;
      endcase
      // Pin one carries the positive/clock/aux-line role in upside-up [RQ5]
      if (orient == TPM_ORIENT_UP) begin
         sb_one_nxt = sb_onehot;
         sb_two_nxt = sb_onehot & 4'b0101;
      end else if (orient == TPM_ORIENT_FLIP) begin
         sb_one_nxt = sb_onehot & 4'b0101; // [RQ3]
         sb_two_nxt = sb_onehot;
      end else begin
         sb_one_nxt = 4'b0000; // [RQ18]
         sb_two_nxt = 4'b0000;
      end
   end

   // Bit 4 of a pair select is never set; pair_onehot uses only bits 0 to 3.
   // Only the d+/d- pairs and sideband pins are driven; high-speed lanes never appear here [RQ6]
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         top_pair_sel <= 5'h00;
         bottom_pair_sel <= 5'h00;
         sideband_pin_one_sel <= 4'h0;
         sideband_pin_two_sel <= 4'h0;
      end else begin
         // Fixed pin pairing per source; orientation chooses top or bottom [RQ4] [RQ1]
         top_pair_sel <= (orient == TPM_ORIENT_UP) ? pair_onehot : 5'h00; // [RQ2]
         bottom_pair_sel <= (orient == TPM_ORIENT_FLIP) ? pair_onehot : 5'h00; // [RQ2]
         sideband_pin_one_sel <= sb_one_nxt;
         sideband_pin_two_sel <= sb_two_nxt;
      end
   end

   // Closed path per pin: sb1, sb2, tp, tn, bp, bn
   assign path_closed = {{2{orient == TPM_ORIENT_FLIP && pair_onehot != 5'h00}},
                         {2{orient == TPM_ORIENT_UP && pair_onehot != 5'h00}},
                         sb_two_nxt != 4'h0, sb_one_nxt != 4'h0};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_clamp_en <= 6'h00;
         pin_pullup_en <= 6'h00;
         pin_pulldown_en <= 6'h00;
         pin_cmp_connect <= 6'h00;
      end else begin
         pin_clamp_en <= path_closed; // [RQ11]
         pin_pullup_en <= pull_ctrl_r[5:0]; // [RQ10]
         pin_pulldown_en <= pull_ctrl_r[11:6]; // [RQ10]
         pin_cmp_connect <= cmp_en_r; // [RQ9]
      end
   end

   // ----------------------------------------------------------------------
   // Endpoint and cable supply
   // ----------------------------------------------------------------------
   // Low-speed, endpoint-zero billboard enumeration lives in firmware/SIE;
   // this block only exposes the low-speed-only strap. [RQ12] [RQ13]
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         endpoint_pullup_top <= 1'b0;
         endpoint_pullup_bottom <= 1'b0;
         endpoint_low_speed_only <= 1'b1;
      end else begin
         endpoint_low_speed_only <= 1'b1; // [RQ12]
         endpoint_pullup_top <= !ep_tx && pair_src == TPM_PAIR_ENDPT
                                && orient == TPM_ORIENT_UP; // [RQ14] [RQ15]
         endpoint_pullup_bottom <= !ep_tx && pair_src == TPM_PAIR_ENDPT
                                   && orient == TPM_ORIENT_FLIP; // [RQ14] [RQ15]
      end
   end

   // Limit level select is a register bit; overcurrent flag comes from the analog
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cable_supply_current_limit <= 1'b0;
         cable_supply_to_cc_one <= 1'b0;
         cable_supply_to_cc_two <= 1'b0;
         modem_to_cc_one <= 1'b0;
         modem_to_cc_two <= 1'b0;
      end else begin
         cable_supply_current_limit <= mux_ctrl_r[`TPM_MC_ILIM_HI]; // [RQ16]
         // Flipped plug: supply goes to pin one, modem to pin two
         cable_supply_to_cc_one <= mux_ctrl_r[`TPM_MC_CABLE_EN]
                                   && orient == TPM_ORIENT_FLIP; // [RQ17]
         cable_supply_to_cc_two <= mux_ctrl_r[`TPM_MC_CABLE_EN]
                                   && orient == TPM_ORIENT_UP; // [RQ17]
         modem_to_cc_one <= orient == TPM_ORIENT_UP;
         modem_to_cc_two <= orient == TPM_ORIENT_FLIP;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_open_unresolved: assert property (@(posedge sys_clk) disable iff (srst) // [RQ18]
      (orient == TPM_ORIENT_OPEN) |=> (top_pair_sel == 5'h00 && bottom_pair_sel == 5'h00
      && sideband_pin_one_sel == 4'h0))
      else $error("paths closed while orientation unresolved");
   a_pair_exclusive: assert property (@(posedge sys_clk) disable iff (srst) // [RQ2]
      !(top_pair_sel != 5'h00 && bottom_pair_sel != 5'h00) && $onehot0(top_pair_sel))
      else $error("top and bottom both driven or two sources");
   a_sb_flip: assert property (@(posedge sys_clk) disable iff (srst) // [RQ3]
      (orient == TPM_ORIENT_FLIP && sb_src == TPM_SB_DBG1) |=> (sideband_pin_two_sel == 4'b0010
      && sideband_pin_one_sel == 4'h0))
      else $error("sideband not flipped");
   a_sb_upright: assert property (@(posedge sys_clk) disable iff (srst) // [RQ5]
      (orient == TPM_ORIENT_UP && sb_src == TPM_SB_DBG1) |=> sideband_pin_one_sel == 4'b0010)
      else $error("aux line not on sideband one");
   a_clamp_path: assert property (@(posedge sys_clk) disable iff (srst) // [RQ11]
      pin_clamp_en[2] == (top_pair_sel != 5'h00)
      && pin_clamp_en[0] == (sideband_pin_one_sel != 4'h0))
      else $error("clamp without closed path");
   a_ep_tx_pullup: assert property (@(posedge sys_clk) disable iff (srst) // [RQ14]
      ep_tx |=> !endpoint_pullup_top && !endpoint_pullup_bottom)
      else $error("pullup during transmit");
   a_edge_irq: assert property (@(posedge sys_clk) disable iff (srst) // [RQ8]
      (cmp_en_r[0] && $changed(sense_s2_r[0])) |=> irq_stat_r[0])
      else $error("edge not captured");
   a_cc_exclusive: assert property (@(posedge sys_clk) disable iff (srst) // [RQ17]
      !(cable_supply_to_cc_one && modem_to_cc_one) && !(cable_supply_to_cc_two && modem_to_cc_two))
      else $error("cc pin both powered and on modem");
   a_ilim_follow: assert property (@(posedge sys_clk) disable iff (srst) // [RQ16]
      $rose(mux_ctrl_r[`TPM_MC_ILIM_HI]) |=> cable_supply_current_limit)
      else $error("limit level not applied");
endmodule // tpm_port_mux

// File: test/tpm_far_end.sv
// Far-end model of the receptacle, cable and attached device on the six port pins.
// Assumes the bench changes drive and pull controls just after rising sys_clk edges.
module tpm_far_end (
   input wire logic sys_clk,
   input wire logic [5:0] drive_en,
   input wire logic [5:0] drive_val,
   input wire logic [5:0] pull_up,
   input wire logic [5:0] pull_dn,
   output logic [5:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] last_r = 6'h00;
   always_ff @(posedge sys_clk) begin
      last_r <= pin_level;
   end
   // Released pins go to their pull, else wander so a stale level is never trusted
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_level[i] = drive_en[i] ? drive_val[i] : pull_up[i] ? 1'b1 :
                        pull_dn[i] ? 1'b0 : ~last_r[i];
      end
   end
endmodule // tpm_far_end

// File: test/typec_port_data_mux_control_bench.sv
// Self-checking bench of the port data mux control: routing by orientation,
// pulls, clamps, comparator interrupts, endpoint pull-up and APB refusals.
// Assumes tpm_map.svh, tpm_pkg, the design and the far-end model compile first.
`include "tpm_map.svh"

module typec_port_data_mux_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, r;
   logic pready, pslverr, err_flag, up, fl;
   logic [5:0] sense, pu, pd, clamp, cmpc;
   logic [5:0] drv_en = 6'h00;
   logic [5:0] drv_val = 6'h00;
   logic ovc = 1'b0;
   logic [4:0] top_sel, bot_sel, et, eb;
   logic [3:0] sb1_sel, sb2_sel, e1, e2;
   logic ep_top, ep_bot, ls_only, ilim, cc1_pwr, cc2_pwr, cc1_mdm, cc2_mdm, irq;
   int err_count = 0;
   int samples_checked = 0;
   int seed = 68;

   always #20 sys_clk = ~sys_clk;

   tpm_port_mux dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pin_sense(sense), .cable_overcurrent(ovc),
      .top_pair_sel(top_sel), .bottom_pair_sel(bot_sel), .sideband_pin_one_sel(sb1_sel),
      .sideband_pin_two_sel(sb2_sel), .pin_pullup_en(pu), .pin_pulldown_en(pd),
      .pin_clamp_en(clamp), .pin_cmp_connect(cmpc), .endpoint_pullup_top(ep_top),
      .endpoint_pullup_bottom(ep_bot), .endpoint_low_speed_only(ls_only),
      .cable_supply_current_limit(ilim), .cable_supply_to_cc_one(cc1_pwr),
      .cable_supply_to_cc_two(cc2_pwr), .modem_to_cc_one(cc1_mdm),
      .modem_to_cc_two(cc2_mdm), .irq(irq));

   tpm_far_end far (.sys_clk(sys_clk), .drive_en(drv_en), .drive_val(drv_val),
      .pull_up(pu), .pull_dn(pd), .pin_level(sense));

   // ----------------------------------------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Starts with an edge so a release never shares a time step with a new setup
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err_flag = pslverr;
      if (n >= 50) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   function automatic logic [4:0] pair_hot(input logic [2:0] s);
      return (s >= 3'h1 && s <= 3'h4) ? 5'(5'h01 << (s - 3'h1)) : 5'h00;
   endfunction

   // own: this pin is the one that carries the single-ended aux line
   function automatic logic [3:0] sb_hot(input logic [2:0] s, input logic own);
      case (s)
         3'h1: return 4'h1;
         3'h2: return own ? 4'h2 : 4'h0;
         3'h3: return 4'h4;
         default: return 4'h0;
      endcase
   endfunction

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #800000;
      err_count++;
      conclude();
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      check(ls_only, 1'b1);
      check({top_sel, bot_sel, sb1_sel, sb2_sel, clamp}, 0);
      for (int a = 0; a <= 20; a += 4) rdchk(12'(a), 32'h0000_0000);
      $display("reset test done");
      for (int o = 0; o < 4; o++) begin
         for (int p = 0; p < 5; p++) begin
            for (int s = 0; s < 4; s++) begin
               r = $random(seed);
               up = (o == 1);
               fl = (o == 2);
               wr(`TPM_OFS_MUX_CTRL, {21'h0, 1'b1, r[1:0], 3'(s), 3'(p), 2'(o)});
               et = up ? pair_hot(3'(p)) : 5'h00;
               eb = fl ? pair_hot(3'(p)) : 5'h00;
               e1 = (up | fl) ? sb_hot(3'(s), up) : 4'h0;
               e2 = (up | fl) ? sb_hot(3'(s), fl) : 4'h0;
               repeat (3) @(posedge sys_clk);
               check(top_sel, et);
               check(bot_sel, eb);
               check({sb1_sel, sb2_sel}, {e1, e2});
               check(clamp, {|eb, |eb, |et, |et, |e2, |e1});
               check({ep_top, ep_bot}, {up && p == 2 && !r[0], fl && p == 2 && !r[0]});
               check({cc1_pwr, cc2_pwr, cc1_mdm, cc2_mdm}, {fl, up, up, fl});
               check(ilim, r[1]);
            end
         end
      end
      $display("routing test done");
      repeat (4) begin
         r = $random(seed);
         wr(`TPM_OFS_PULL_CTRL, {20'h0, r[11:0]});
         repeat (3) @(posedge sys_clk);
         check({pd, pu}, r[11:0]);
      end
      wr(`TPM_OFS_MUX_CTRL, 32'h0000_0000);
      wr(`TPM_OFS_PULL_CTRL, 32'h0000_0000);
      drv_en <= 6'h3f;
      wr(`TPM_OFS_CMP_EN, 32'h0000_0015);
      wr(`TPM_OFS_IRQ_CLR, 32'h0000_007f);
      wr(`TPM_OFS_IRQ_EN, 32'h0000_007f);
      check(cmpc, 6'h15);
      check(irq, 1'b0);
      drv_val <= 6'h3f;
      repeat (6) @(posedge sys_clk);
      rdchk(`TPM_OFS_IRQ_STAT, 32'h0000_0015);
      check(irq, 1'b1);
      rdchk(`TPM_OFS_PORT_STAT, 32'h0000_003f);
      ovc <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(`TPM_OFS_PORT_STAT, 32'h0000_00bf);
      wr(`TPM_OFS_IRQ_STAT, 32'h0000_0000);
      rdchk(`TPM_OFS_IRQ_STAT, 32'h0000_0015);
      wr(`TPM_OFS_IRQ_EN, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      check(irq, 1'b0);
      wr(`TPM_OFS_IRQ_CLR, 32'h0000_0004);
      rdchk(`TPM_OFS_IRQ_STAT, 32'h0000_0011);
      wr(`TPM_OFS_IRQ_CLR, 32'h0000_003f);
      wr(`TPM_OFS_IRQ_EN, 32'h0000_007f);
      wr(`TPM_OFS_MUX_CTRL, 32'h0000_0200);
      repeat (3) @(posedge sys_clk);
      check({ilim, irq}, 2'b11);
      rdchk(`TPM_OFS_IRQ_STAT, 32'h0000_0040);
      wr(`TPM_OFS_MUX_CTRL, 32'h0000_0000);
      wr(`TPM_OFS_IRQ_CLR, 32'h0000_0040);
      rdchk(`TPM_OFS_IRQ_STAT, 32'h0000_0000);
      check(irq, 1'b0);
      $display("interrupt test done");
      apb(1'b0, 12'h01c, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check(err_flag, 1'b1);
      apb(1'b1, 12'h0ff, 32'hffff_ffff);
      check(err_flag, 1'b1);
      rdchk(`TPM_OFS_MUX_CTRL, 32'h0000_0000);
      check(err_flag, 1'b0);
      $display("refusal test done");
      conclude();
   end
endmodule // typec_port_data_mux_control_bench
